// >>> gauge_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 50 MHz core clock and a word-addressed avalon-mm slave
`ifndef GAUGE_REGS_SVH
`define GAUGE_REGS_SVH

// word indices (byte address = 4 * index)
`define REG_CONTROL        6'h00
`define REG_CURRENT        6'h01
`define REG_TEMPERATURE    6'h02
`define REG_VOLTAGE        6'h03
`define REG_FLAGS          6'h04
`define REG_IRQ            6'h05
`define REG_SOC            6'h06
`define REG_DESIGN_CAP     6'h07
`define REG_ALERT_EN       6'h08
`define REG_MODE_CFG       6'h09
`define REG_AVG_VOLTAGE    6'h0A
`define REG_AVG_CURRENT    6'h0B
`define REG_AVG_TEMP       6'h0C
`define REG_STATUS         6'h0D
`define REG_DEVICE_ID      6'h0E

// reset values and command codes
`define DESIGN_CAP_RST     16'h07D0
`define QUICK_SENSE_CMD    16'h4000
`define SHUTDOWN_CMD_SCL   16'h0030
`define SHUTDOWN_CMD_ATTN  16'h0031
`define SLEEP_ENTER_CMD    16'h0020
`define SLEEP_EXIT_CMD     16'h0021
`define SLEEP_MULT_RST     5'h04
`define DEVICE_ID_VAL      16'h5A5A  // arbitrary value

// mode_cfg field positions
`define CFG_SLEEP_EN       0
`define CFG_SHDN_EN        1
`define CFG_TEMP_EXT       2
`define CFG_NOTIFY_EN      3
`define CFG_MULT_LSB       8
`define CFG_DELAY_LSB      16

// timing
`define CLK_HZ             50000000
`define FIRST_MS           250
`define PERIOD_MS          1000
`define WAKE_US            20
`define FIRST_CYC          (`CLK_HZ / 1000 * `FIRST_MS)
`define PERIOD_CYC         (`CLK_HZ / 1000 * `PERIOD_MS)
`define WAKE_CYC           ((`CLK_HZ / 1000000) * `WAKE_US)
`define SEC_CYC            `CLK_HZ

`endif

// >>> gauge_pkg.sv
// types shared by the gauge control block
// assumes gauge_regs.svh is compiled alongside
package gauge_pkg;
    // power states of the measurement sequencer
    typedef enum logic [2:0] {
        PM_STARTUP,
        PM_ACTIVE,
        PM_SLEEP,
        PM_SHDN_WAIT,
        PM_SHUTDOWN
    } power_mode_t;
endpackage

// >>> gauge_ctrl.sv
// gauge control: measurement schedule, power modes, alert engine
// assumes converter results on same clock, scl/attn pins asynchronous
`include "gauge_regs.svh"

// What this block does
// (RULE1) voltage reported at one millivolt per lsb
// (RULE2) first result 250 ms, then every second
// (RULE3) voltage refreshed one second after sleep exit
// (RULE4) signed current at one milliampere per lsb
// (RULE5) temperature from thermistor or on-chip sensor
// (RULE6) design capacity resets 0x07D0, only host writes
// (RULE7) charge percent read-only, first at 250 ms
// (RULE8) initial charge from voltage, then gradual
// (RULE9) active, sleep, shutdown; active after reset
// (RULE10) active mode refreshes all results every second
// (RULE11) sleep period two to sixteen, default four
// (RULE12) sleep by command or self detection once enabled
// (RULE13) shutdown drops regulator and working data
// (RULE14) shutdown needs enable, command, then delay
// (RULE15) wake on rising edge of selected pin
// (RULE16) command 0x4000 restarts sensing and estimate
// (RULE17) nine alert conditions are provided
// (RULE18) alert inactive until enable or threshold written
// (RULE19) flag follows condition only while enabled
// (RULE20) irq set only on flag change with notify
// (RULE21) irq and pin clear only on irq read or on wake from shutdown
// (RULE22) disabling an alert clears its flag
// (RULE23) attention pin open drain, pulls low only
// (RULE24) wake pin low at least 20 us first
// (RULE25) shutdown delay one to 256 seconds
// (RULE26) wake restarts power-up sequence in active mode
module gauge_ctrl
    import gauge_pkg::*;
#(
    parameter int unsigned PERIOD_CYCLES = `PERIOD_CYC,
    parameter int unsigned FIRST_CYCLES  = `FIRST_CYC,
    parameter int unsigned SEC_CYCLES    = `SEC_CYC
) (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // avalon-mm slave
    input  wire logic [5:0]  i_address,
    input  wire logic        i_read,
    input  wire logic        i_write,
    input  wire logic [31:0] i_writedata,
    input  wire logic [3:0]  i_byteenable,
    output logic      [31:0] o_readdata,
    output logic             o_waitrequest,
    // converter results, same clock
    input  wire logic [15:0] i_adc_voltage,
    input  wire logic [15:0] i_adc_current,
    input  wire logic [15:0] i_adc_temp_ext,
    input  wire logic [15:0] i_adc_temp_int,
    input  wire logic [7:0]  i_est_soc,
    input  wire logic [7:0]  i_ocv_soc,
    input  wire logic        i_idle_detect,
    // alert conditions and threshold writes, same clock
    input  wire logic [8:0]  i_alert_cond,
    input  wire logic [8:0]  i_thresh_written,
    // pins, asynchronous
    input  wire logic        i_scl,
    input  wire logic        i_attn,
    output logic             o_attn_n_o,
    output logic             o_attn_n_oe,
    // power and converter control
    output logic             o_regulator_on,
    output logic             o_convert
);

    ////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        power_mode_t mode;          // power state
        logic [31:0] tick;          // cycles into current period
        logic [4:0]  sleep_mult;    // sleep period in active periods
        logic [4:0]  sleep_cnt;     // active periods elapsed in sleep
        logic [8:0]  shdn_secs;     // seconds left before shutdown, minus one
        logic        wake_sel;      // 0 scl, 1 attention pin
        logic [15:0] low_cnt;       // wake pin low duration
        logic [1:0]  scl_s;         // scl synchroniser
        logic [1:0]  attn_s;        // attention synchroniser

        logic        sleep_en;      // sleep function enabled
        logic        shdn_en;       // shutdown function enabled
        logic        temp_ext;      // thermistor source
        logic        notify_en;     // irq notify enable
        logic [8:0]  shdn_delay;    // delay minus one, seconds

        logic [8:0]  alert_en;      // per-alert enable
        logic [8:0]  flags;         // per-alert flag
        logic        irq;           // sticky interrupt

        logic [15:0] voltage;       // mV
        logic [15:0] current;       // mA signed
        logic [15:0] temp;          // result
        logic [15:0] avg_v;
        logic [15:0] avg_i;
        logic [15:0] avg_t;
        logic [7:0]  soc;           // percent
        logic [15:0] design_cap;    // mAh

        logic        convert;       // one-cycle conversion strobe
        logic        ack;           // bus answer phase
        logic [31:0] rdata;
    } state_t;

    state_t s_q, s_d;

    // running average of two samples
    function automatic logic [15:0] avg2(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] sum;
        sum = {a[15], a} + {b[15], b};
        return sum[16:1];
    endfunction

    logic        access;    // bus request taken this cycle
    logic        period_end;

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        s_d         = s_q;
        s_d.convert = 1'b0;
        // two-flop pin sync
        s_d.scl_s   = {s_q.scl_s[0], i_scl};
        s_d.attn_s  = {s_q.attn_s[0], i_attn};

        // one answer per request
        access      = (i_read | i_write) & ~s_q.ack;
        s_d.ack     = access;

        period_end  = 1'b0;

        // measurement schedule
        s_d.tick = s_q.tick + 32'h1;

        case (s_q.mode)
            PM_STARTUP: begin
                if (s_q.tick == FIRST_CYCLES - 1) begin
                    // first conversion and voltage-only estimate [RULE2] [RULE8] [RULE7]
                    s_d.tick    = 32'h0;
                    s_d.voltage = i_adc_voltage;          // [RULE1]
                    s_d.avg_v   = i_adc_voltage;
                    s_d.soc     = i_ocv_soc;
                    s_d.convert = 1'b1;
                    s_d.mode    = PM_ACTIVE;              // [RULE9]
                end
            end

            PM_ACTIVE, PM_SLEEP, PM_SHDN_WAIT: begin
                // one active period elapsed
                if (s_q.tick == PERIOD_CYCLES - 1) begin
                    s_d.tick = 32'h0;
                    // sleep stretches period by multiplier [RULE11]
                    if (s_q.mode == PM_SLEEP && s_q.sleep_cnt != s_q.sleep_mult - 5'h1) begin
                        s_d.sleep_cnt = s_q.sleep_cnt + 5'h1;
                    end else begin
                        period_end    = 1'b1;
                        s_d.sleep_cnt = 5'h0;
                    end
                    // seconds of shutdown delay [RULE14] [RULE25]
                    if (s_q.mode == PM_SHDN_WAIT) begin
                        if (s_q.shdn_secs == 9'h0) begin
                            s_d.mode = PM_SHUTDOWN;       // [RULE13]
                        end else begin
                            s_d.shdn_secs = s_q.shdn_secs - 9'h1;
                        end
                    end
                end
                if (period_end) begin
                    // results written only at period end [RULE2] [RULE10]
                    s_d.convert = 1'b1;
                    s_d.voltage = i_adc_voltage;
                    s_d.current = i_adc_current;          // [RULE4]
                    s_d.temp    = s_q.temp_ext ? i_adc_temp_ext : i_adc_temp_int; // [RULE5]
                    s_d.avg_v   = avg2(s_q.avg_v, i_adc_voltage);
                    s_d.avg_i   = avg2(s_q.avg_i, i_adc_current);
                    s_d.avg_t   = avg2(s_q.avg_t, s_d.temp);
                    s_d.soc     = i_est_soc;              // gradual estimate [RULE8]
                end

                // self detection of idle enters/leaves sleep [RULE12]
                if (s_q.sleep_en && s_q.mode == PM_ACTIVE && i_idle_detect && period_end) begin
                    s_d.mode = PM_SLEEP;
                end else if (s_q.mode == PM_SLEEP && !i_idle_detect) begin
                    s_d.mode = PM_ACTIVE;                 // [RULE3]
                    s_d.tick = 32'h0;
                    s_d.sleep_cnt = 5'h0;
                end
            end

            PM_SHUTDOWN: begin
                // wake on rising edge after long enough low [RULE15] [RULE24]
                s_d.tick = 32'h0;

                // selected pin low time
                if (!(s_q.wake_sel ? s_q.attn_s[1] : s_q.scl_s[1])) begin
                    if (s_q.low_cnt != 16'hFFFF) s_d.low_cnt = s_q.low_cnt + 16'h1;
                end else begin
                    s_d.low_cnt = 16'h0;
                    if (s_q.low_cnt >= 16'(`WAKE_CYC)) begin
                        // volatile data lost, restart power-up [RULE26] [RULE13]
                        s_d.mode       = PM_STARTUP;
                        s_d.flags      = 9'h0;
                        s_d.irq        = 1'b0;
                        s_d.alert_en   = 9'h0;
                        s_d.notify_en  = 1'b0;
                        s_d.design_cap = `DESIGN_CAP_RST;
                        s_d.shdn_en    = 1'b0;
                        s_d.sleep_en   = 1'b0;
                        s_d.sleep_mult = `SLEEP_MULT_RST;
                        s_d.temp_ext   = 1'b0;
                        s_d.shdn_delay = 9'h0;
                    end
                end
            end

            default: s_d.mode = PM_STARTUP;
        endcase

        // alert flags follow condition while enabled [RULE17] [RULE19]
        s_d.flags = s_d.flags & s_q.alert_en & s_d.alert_en;

        if (s_q.mode != PM_SHUTDOWN) begin
            s_d.flags = i_alert_cond & s_q.alert_en;
            // threshold writes enable an alert too [RULE18]
            s_d.alert_en = s_q.alert_en | i_thresh_written;
        end

        // register writes
        if (access && i_write && s_q.mode != PM_SHUTDOWN) begin
            if (i_address == `REG_CONTROL) begin
                if (i_writedata[15:0] == `QUICK_SENSE_CMD) begin
                    // restart sensing and estimate [RULE16]
                    s_d.mode = PM_STARTUP;
                    s_d.tick = 32'h0;
                end else if (i_writedata[15:0] == `SLEEP_ENTER_CMD && s_q.sleep_en) begin
                    s_d.mode = PM_SLEEP;                  // [RULE12]
                end else if (i_writedata[15:0] == `SLEEP_EXIT_CMD && s_q.mode == PM_SLEEP) begin
                    s_d.mode = PM_ACTIVE;
                    s_d.tick = 32'h0;
                end else if (s_q.shdn_en && (i_writedata[15:0] == `SHUTDOWN_CMD_SCL
                             || i_writedata[15:0] == `SHUTDOWN_CMD_ATTN)) begin
                    // enable first, then command [RULE14]
                    s_d.mode      = PM_SHDN_WAIT;
                    s_d.wake_sel  = i_writedata[0];
                    s_d.shdn_secs = s_q.shdn_delay;
                    s_d.tick      = 32'h0;
                end
            end else if (i_address == `REG_DESIGN_CAP) begin
                if (i_byteenable[0]) s_d.design_cap[7:0]  = i_writedata[7:0];   // [RULE6]
                if (i_byteenable[1]) s_d.design_cap[15:8] = i_writedata[15:8];
            end else if (i_address == `REG_ALERT_EN && i_byteenable[1:0] == 2'b11) begin
                s_d.alert_en = i_writedata[8:0];
                s_d.flags    = s_d.flags & i_writedata[8:0]; // [RULE22]
            end else if (i_address == `REG_MODE_CFG && i_byteenable == 4'hF) begin
                s_d.sleep_en  = i_writedata[`CFG_SLEEP_EN];
                s_d.shdn_en   = i_writedata[`CFG_SHDN_EN];
                s_d.temp_ext  = i_writedata[`CFG_TEMP_EXT];
                s_d.notify_en = i_writedata[`CFG_NOTIFY_EN]; // clearing leaves irq [RULE21]
                if (i_writedata[`CFG_MULT_LSB +: 5] >= 5'h2 && i_writedata[`CFG_MULT_LSB +: 5] <= 5'h10) begin
                    s_d.sleep_mult = i_writedata[`CFG_MULT_LSB +: 5]; // [RULE11]
                end
                s_d.shdn_delay = {1'b0, i_writedata[`CFG_DELAY_LSB +: 8]}; // 1..256 s [RULE25]
            end
        end

        // read clear of irq, before set so a new change wins [RULE21]
        if (access && i_read && i_address == `REG_IRQ) s_d.irq = 1'b0;

        // irq on flag change under notify only [RULE20]
        if (s_q.notify_en && (s_d.flags != s_q.flags)) s_d.irq = 1'b1;

        // read data
        if (access && i_read) begin
            if (i_address == `REG_CONTROL)          s_d.rdata = {29'h0, s_q.mode};
            else if (i_address == `REG_CURRENT)     s_d.rdata = {16'h0, s_q.current};
            else if (i_address == `REG_TEMPERATURE) s_d.rdata = {16'h0, s_q.temp};
            else if (i_address == `REG_VOLTAGE)     s_d.rdata = {16'h0, s_q.voltage};
            else if (i_address == `REG_FLAGS)       s_d.rdata = {23'h0, s_q.flags};
            else if (i_address == `REG_IRQ)         s_d.rdata = {31'h0, s_q.irq};
            else if (i_address == `REG_SOC)         s_d.rdata = {24'h0, s_q.soc};
            else if (i_address == `REG_DESIGN_CAP)  s_d.rdata = {16'h0, s_q.design_cap};
            else if (i_address == `REG_ALERT_EN)    s_d.rdata = {23'h0, s_q.alert_en};
            else if (i_address == `REG_MODE_CFG)
                s_d.rdata = {8'h0, s_q.shdn_delay[7:0], 3'h0, s_q.sleep_mult, 4'h0,
                             s_q.notify_en, s_q.temp_ext, s_q.shdn_en, s_q.sleep_en};
            else if (i_address == `REG_AVG_VOLTAGE) s_d.rdata = {16'h0, s_q.avg_v};
            else if (i_address == `REG_AVG_CURRENT) s_d.rdata = {16'h0, s_q.avg_i};
            else if (i_address == `REG_AVG_TEMP)    s_d.rdata = {16'h0, s_q.avg_t};
            else if (i_address == `REG_STATUS)      s_d.rdata = {28'h0, s_q.wake_sel, s_q.mode};
            else if (i_address == `REG_DEVICE_ID)   s_d.rdata = {16'h0, `DEVICE_ID_VAL}; // arbitrary
            else                                    s_d.rdata = 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q            <= '0;
            s_q.mode       <= PM_STARTUP;                 // [RULE9]
            s_q.sleep_mult <= `SLEEP_MULT_RST;
            s_q.design_cap <= `DESIGN_CAP_RST;            // [RULE6]
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all from flops
    assign o_readdata     = s_q.rdata;
    assign o_waitrequest  = ~s_q.ack;

    assign o_attn_n_o     = 1'b0;       // pull low only [RULE23]
    assign o_attn_n_oe    = s_q.irq;    // [RULE23]

    assign o_regulator_on = (s_q.mode != PM_SHUTDOWN);
    assign o_convert      = s_q.convert;

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_irq_only_notify;
        @(posedge i_clk) disable iff (i_rst)
        $rose(s_q.irq) |-> $past(s_q.notify_en);
    endproperty
    a_irq_only_notify: assert property (p_irq_only_notify) else $error("irq set without notify"); // [RULE20]

    property p_irq_hold;
        @(posedge i_clk) disable iff (i_rst)
        $fell(s_q.irq) |-> $past(access && i_read && i_address == `REG_IRQ) || s_q.mode == PM_STARTUP;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq cleared without read"); // [RULE21]

    property p_flag_gated;
        @(posedge i_clk) disable iff (i_rst)
        (s_q.flags & ~s_q.alert_en) == 9'h0;
    endproperty
    a_flag_gated: assert property (p_flag_gated) else $error("flag set while disabled"); // [RULE19]

    property p_pin_low_only;
        @(posedge i_clk) disable iff (i_rst)
        o_attn_n_o == 1'b0 && o_attn_n_oe == s_q.irq;
    endproperty
    a_pin_low_only: assert property (p_pin_low_only) else $error("attention pin driven high"); // [RULE23]

    property p_first_at_startup;
        @(posedge i_clk) disable iff (i_rst)
        (s_q.mode == PM_STARTUP && s_d.mode == PM_ACTIVE) |=> o_convert;
    endproperty
    a_first_at_startup: assert property (p_first_at_startup) else $error("no first conversion"); // [RULE2]

    property p_shdn_needs_wait;
        @(posedge i_clk) disable iff (i_rst)
        $rose(s_q.mode == PM_SHUTDOWN) |-> $past(s_q.mode) == PM_SHDN_WAIT;
    endproperty
    a_shdn_needs_wait: assert property (p_shdn_needs_wait) else $error("shutdown without delay"); // [RULE14]

    property p_mult_range;
        @(posedge i_clk) disable iff (i_rst)
        s_q.sleep_mult >= 5'h2 && s_q.sleep_mult <= 5'h10;
    endproperty
    a_mult_range: assert property (p_mult_range) else $error("sleep multiplier out of range"); // [RULE11]

    property p_wake_low;
        @(posedge i_clk) disable iff (i_rst)
        (s_q.mode == PM_SHUTDOWN && s_d.mode == PM_STARTUP) |-> s_q.low_cnt >= 16'(`WAKE_CYC);
    endproperty
    a_wake_low: assert property (p_wake_low) else $error("wake with short low"); // [RULE24]

endmodule

// >>> gauge_host_pins.sv
// host-side model of the wake pins: serial clock line and attention line
// assumes pull-ups on both lines and a bench that calls its tasks
module gauge_host_pins (
    // attention pin of the device
    input  wire logic i_attn_n_o,
    input  wire logic i_attn_n_oe,
    // line levels seen by the device
    output logic      o_scl,
    output logic      o_attn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic scl_low  = 1'b0;  // host pulls the serial clock low
    logic attn_low = 1'b0;  // host pulls the attention line low
    ////////////////////////////////////////////////////////////////////////
    // wired-and with pull-ups: a released line reads high, never stale
    assign o_scl  = ~scl_low;
    assign o_attn = (i_attn_n_oe ? i_attn_n_o : 1'b1) & ~attn_low;
    // hold the chosen wake pin low, then let it rise
    task automatic hold_low(input bit on_attn, input int ns);
        if (on_attn) begin
            attn_low = 1'b1;
        end else begin
            scl_low = 1'b1;
        end
        #(ns);  // low time decides whether the rise counts
        attn_low = 1'b0;
        scl_low  = 1'b0;
    endtask
    // a short frame of 160 ns link clock; the line rests high outside it
    task automatic scl_burst(input int n);
        repeat (n) begin
            scl_low = 1'b1;
            #80;
            scl_low = 1'b0;
            #80;
        end
    endtask
endmodule

// >>> gauge_ctrl_tb.sv
// self-checking bench of the gauge control block
// assumes shortened periods: one second = 100 cycles, first result 25
`include "gauge_regs.svh"
module gauge_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int P = 100;  // shortened one-second period
    localparam int F = 25;   // shortened first-result time
    logic        i_clk = 1'b0, i_rst = 1'b1, i_read = 1'b0, i_write = 1'b0;
    logic [5:0]  i_address = 6'h00;
    logic [31:0] i_writedata = 32'h0, o_readdata, q;
    logic [15:0] adc_v = 16'h0, adc_i = 16'h0, adc_te = 16'h0, adc_ti = 16'h0;
    logic [7:0]  est_soc = 8'h00, ocv_soc = 8'h00;
    logic [8:0]  cond = 9'h000, thr = 9'h000;
    logic        idle = 1'b0, o_waitrequest, attn_o, attn_oe, reg_on, conv;
    wire         scl, attn;
    int          num_errors = 0, check_count = 0, cyc = 0, gap;
    int          model_cap;  // behavioural copy of the capacity register
    ////////////////////////////////////////////////////////////////////////
    always #10 i_clk = ~i_clk;
    gauge_ctrl #(.PERIOD_CYCLES(P), .FIRST_CYCLES(F), .SEC_CYCLES(P)) dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_address(i_address), .i_read(i_read),
        .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(4'hF),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
        .i_adc_voltage(adc_v), .i_adc_current(adc_i), .i_adc_temp_ext(adc_te),
        .i_adc_temp_int(adc_ti), .i_est_soc(est_soc), .i_ocv_soc(ocv_soc),
        .i_idle_detect(idle), .i_alert_cond(cond), .i_thresh_written(thr),
        .i_scl(scl), .i_attn(attn), .o_attn_n_o(attn_o), .o_attn_n_oe(attn_oe),
        .o_regulator_on(reg_on), .o_convert(conv));
    gauge_host_pins host (.i_attn_n_o(attn_o), .i_attn_n_oe(attn_oe), .o_scl(scl), .o_attn(attn));
    ////////////////////////////////////////////////////////////////////////
    // closing report, reached from the main sequence or the hang guard
    task automatic test_done();
        if (num_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // cycle counts may slip by a few cycles of synchroniser latency
    task automatic near(input int got, input int exp);
        chk((got < exp - 4 || got > exp + 4) ? 16'(got) : 16'(exp), 16'(exp));
    endtask
    // one avalon cycle: request held until waitrequest is sampled low
    task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d);
        @(posedge i_clk);
        i_address   <= a;
        i_write     <= w;
        i_read      <= ~w;
        i_writedata <= d;
        do begin
            @(posedge i_clk);
        end while (o_waitrequest !== 1'b0);
        q = o_readdata;
        i_read  <= 1'b0;
        i_write <= 1'b0;
    endtask
    // cycles until the next result update, with no limit of its own but the hang guard
    task automatic wait_conv(output int n);
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (conv !== 1'b1);
    endtask
    function automatic logic [31:0] cfg(input logic [3:0] b, input int mult, input int dly);
        return {8'h00, 8'(dly), 3'h0, 5'(mult), 4'h0, b};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // hang guard, well above the expected run of some 6000 cycles
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            test_done();
        end
    end
    initial begin
        void'($urandom(32'h71BB66B5));
        adc_v   <= 16'($urandom_range(2500, 5500));
        adc_i   <= 16'($urandom);
        adc_ti  <= 16'($urandom);
        adc_te  <= 16'($urandom);
        ocv_soc <= 8'($urandom_range(0, 100));
        est_soc <= 8'($urandom_range(0, 100));
        model_cap = 16'h07D0;
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        // start-up: first result after the short period, from voltage
        wait_conv(gap);
        near(gap, F);
        bus(`REG_VOLTAGE, 1'b0, 32'h0);
        chk(q[15:0], adc_v);
        bus(`REG_SOC, 1'b1, 32'hFF);
        bus(`REG_SOC, 1'b0, 32'h0);
        chk(q[15:0], {8'h00, ocv_soc});
        wait_conv(gap);
        bus(`REG_TEMPERATURE, 1'b0, 32'h0);
        chk(q[15:0], adc_ti);
        bus(`REG_AVG_VOLTAGE, 1'b0, 32'h0);
        chk(q[15:0], adc_v);
        bus(`REG_MODE_CFG, 1'b0, 32'h0);
        chk({11'h0, q[12:8]}, 16'h0004);
        bus(`REG_DESIGN_CAP, 1'b0, 32'h0);
        chk(q[15:0], 16'(model_cap));
        model_cap = $urandom_range(100, 9000);
        bus(`REG_DESIGN_CAP, 1'b1, 32'(model_cap));
        bus(6'h3F, 1'b0, 32'h0);
        chk(q[15:0], 16'h0000);
        // external thermistor selected, steady one-second refresh
        bus(`REG_MODE_CFG, 1'b1, cfg(4'h4, 4, 0));
        adc_v <= adc_v + 16'h0011;
        adc_i <= ~adc_i;
        wait_conv(gap);
        wait_conv(gap);
        near(gap, P);
        bus(`REG_CURRENT, 1'b0, 32'h0);
        chk(q[15:0], adc_i);
        bus(`REG_TEMPERATURE, 1'b0, 32'h0);
        chk(q[15:0], adc_te);
        bus(`REG_SOC, 1'b0, 32'h0);
        chk(q[15:0], {8'h00, est_soc});
        bus(`REG_DESIGN_CAP, 1'b0, 32'h0);
        chk(q[15:0], 16'(model_cap));
        // quick sense redoes the voltage-only estimate
        ocv_soc <= est_soc + 8'h07;
        bus(`REG_CONTROL, 1'b1, 32'(`QUICK_SENSE_CMD));
        wait_conv(gap);
        bus(`REG_SOC, 1'b0, 32'h0);
        chk(q[15:0], {8'h00, ocv_soc});
        // alerts: ignored until enabled, irq only on a change with notify
        cond <= 9'h001;
        bus(`REG_FLAGS, 1'b0, 32'h0);
        chk(q[15:0], 16'h0000);
        bus(`REG_ALERT_EN, 1'b1, 32'h1);
        bus(`REG_FLAGS, 1'b0, 32'h0);
        chk(q[15:0], 16'h0001);
        bus(`REG_MODE_CFG, 1'b1, cfg(4'hC, 4, 0));
        bus(`REG_FLAGS, 1'b0, 32'h0);
        chk({15'h0, attn_oe}, 16'h0000);
        cond <= 9'h000;
        bus(`REG_FLAGS, 1'b0, 32'h0);
        chk(q[15:0], 16'h0000);
        chk({14'h0, attn_oe, attn}, 16'h0002);
        bus(`REG_MODE_CFG, 1'b1, cfg(4'h4, 4, 0));
        chk({15'h0, attn_oe}, 16'h0001);
        bus(`REG_IRQ, 1'b0, 32'h0);
        chk(q[15:0], 16'h0001);
        bus(`REG_FLAGS, 1'b0, 32'h0);
        chk({15'h0, attn_oe}, 16'h0000);
        thr  <= 9'h100;
        cond <= 9'h100;
        @(posedge i_clk);
        thr <= 9'h000;
        bus(`REG_FLAGS, 1'b0, 32'h0);
        chk(q[15:0], 16'h0100);
        bus(`REG_ALERT_EN, 1'b1, 32'h1FF);
        cond <= 9'($urandom);
        bus(`REG_FLAGS, 1'b0, 32'h0);
        chk(q[15:0], {7'h0, cond});
        bus(`REG_ALERT_EN, 1'b1, 32'h0);
        bus(`REG_FLAGS, 1'b0, 32'h0);
        chk(q[15:0], 16'h0000);
        cond <= 9'h000;
        // sleep by command, left by self-detection
        bus(`REG_MODE_CFG, 1'b1, cfg(4'h1, 4, 0));
        idle <= 1'b1;
        bus(`REG_CONTROL, 1'b1, 32'(`SLEEP_ENTER_CMD));
        wait_conv(gap);
        wait_conv(gap);
        near(gap, 4 * P);
        idle <= 1'b0;
        wait_conv(gap);
        near(gap, P);
        // shutdown with each wake pin in turn
        for (int sel = 0; sel < 2; sel++) begin
            bus(`REG_MODE_CFG, 1'b1, cfg(4'h2, 4, 0));
            bus(`REG_CONTROL, 1'b1, 32'(sel ? `SHUTDOWN_CMD_ATTN : `SHUTDOWN_CMD_SCL));
            repeat (P / 2) @(posedge i_clk);
            chk({15'h0, reg_on}, 16'h0001);
            gap = P / 2;
            while (reg_on !== 1'b0 && gap < 3 * P) begin
                @(posedge i_clk);
                gap++;
            end
            near(gap, P);
            host.scl_burst(20);
            host.hold_low(sel, 10000);
            repeat (10) @(posedge i_clk);
            chk({15'h0, reg_on}, 16'h0000);
            host.hold_low(sel, 25000);
            wait_conv(gap);
            near(gap, F + 3);
            bus(`REG_DESIGN_CAP, 1'b0, 32'h0);
            chk(q[15:0], 16'h07D0);
        end
        test_done();
    end
endmodule
